// >>> ssc_pkg.sv
// Package for the serial shift clock select block: register map, field positions, resets.
// Assumes a single 40 MHz clock domain and a plain strobe-style register port.
package ssc_pkg;
   // Register offsets
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_PINPOS = 4'h1;
   localparam logic [3:0] ADDR_DATA = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   // Control and pin position field positions
   localparam int CS_HI = 3;
   localparam int CS_LO = 2;
   localparam int CLK_STROBE_POS = 1;
   localparam int TOGGLE_POS = 0;
   localparam int PIN_GROUP_POS = 0;
   // Reset values
   localparam logic [1:0] CS_RESET = 2'h0;
   localparam logic CLK_SEL_RESET = 1'h0;
   localparam logic PIN_GROUP_RESET = 1'h0;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [3:0] CNT_RESET = 4'h0;
   localparam logic CLK_PORT_RESET = 1'h0;
   // Clock source encodings
   typedef enum logic [1:0]
   {
      SSC_CS_SOFT = 2'h0,
      SSC_CS_TIMER = 2'h1,
      SSC_CS_EXT_RISE = 2'h2,
      SSC_CS_EXT_FALL = 2'h3
   } ssc_cs_type;
endpackage : ssc_pkg

// >>> ssc_buf_if.sv
// Interface carrying the received-byte stream between the core and its buffer.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ssc_buf_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ssc_buf_if
`default_nettype wire

// >>> ssc_sync.sv
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the pin is unrelated to i_mclk.
`timescale 1ns/1ps
`default_nettype none
module ssc_sync
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_async,
   output logic o_sync
);
   logic meta_q;
   // First flop feeds only the second
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         meta_q <= 1'h0;
         o_sync <= 1'h0;
      end
      else if (i_ce)
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : ssc_sync
`default_nettype wire

// >>> ssc_fifo2.sv
// Two-entry buffer for completed bytes, valid/ready on both sides.
// Assumes source and sink on i_mclk.
`timescale 1ns/1ps
`default_nettype none
module ssc_fifo2
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   ssc_buf_if.snk in_if,
   output logic o_valid,
   output logic [7:0] o_data,
   input wire logic i_ready
);
   logic [7:0] mem_q [2];
   logic wr_q;
   logic rd_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;
   // Handshakes
   assign in_if.ready = (cnt_q != 2'h2);
   assign o_valid = (cnt_q != 2'h0);
   assign o_data = mem_q[rd_q];
   assign push = in_if.valid && in_if.ready;
   assign pop = o_valid && i_ready;
   // Storage and pointers
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         wr_q <= 1'h0;
         rd_q <= 1'h0;
         cnt_q <= 2'h0;
         mem_q[0] <= 8'h00;
         mem_q[1] <= 8'h00;
      end
      else if (i_ce)
      begin
         if (push)
         begin
            mem_q[wr_q] <= in_if.data;
            wr_q <= ~wr_q;
         end
         if (pop)
         begin
            rd_q <= ~rd_q;
         end
         if (push && !pop)
         begin
            cnt_q <= cnt_q + 2'h1;
         end
         else if (pop && !push)
         begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end
endmodule : ssc_fifo2
`default_nettype wire

// >>> ssc_core.sv
// Serial shift clock select: source selection, strobes, shift register, counter, pins.
// Assumes one 40 MHz clock; serial clock and data pins are asynchronous and are synchronised.
//
// Overview of operation
// R01: Two-bit field selects register and counter clock
// R02: External clock: output changes on opposite edge
// R03: Strobe or timer source: output latch transparent
// R04: Field zero with strobe zero gives no clock
// R05: Encoding: timer, rising, falling, counter both edges
// R06: Software strobe shifts register, increments counter
// R07: Strobe output change same cycle as write
// R08: Shifted bit is input sampled one cycle before
// R09: Clock strobe and toggle bits read zero
// R10: Upper bit one: strobe bit selects counter clock
// R11: Toggle write inverts clock port value
// R12: Software sets clock pin direction for output
// R13: External plus strobe bit: toggle clocks counter
// R14: Pin group bit picks default or alternate pins
// R15: Pin position bits seven to one read zero
// R16: Software sets data input pin as input
// R17: Counter four bits, wraps fifteen to zero
`timescale 1ns/1ps
`default_nettype none
module ssc_core
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_timer_match,
   input wire logic i_clk_pin_dir,
   input wire logic i_sck_a,
   input wire logic i_sck_b,
   input wire logic i_di_a,
   input wire logic i_di_b,
   output logic o_sck_a,
   output logic o_sck_oe_a,
   output logic o_sck_b,
   output logic o_sck_oe_b,
   output logic o_do_a,
   output logic o_do_b,
   output logic o_byte_valid,
   output logic [7:0] o_byte_data,
   input wire logic i_byte_ready
);
   ssc_buf_if buf_if ();
   logic [1:0] cs_q;
   logic clk_sel_q;
   logic pin_group_q;
   logic [7:0] data_q;
   logic [3:0] cnt_q;
   logic clk_port_q;
   logic do_latch_q;
   logic di_prev_q;
   logic sck_prev_q;
   logic [7:0] rdata_q;
   logic pend_q;
   logic sck_a_s;
   logic sck_b_s;
   logic di_a_s;
   logic di_b_s;
   logic sck_s;
   logic di_s;
   logic ctrl_wr;
   logic soft_strobe;
   logic toggle_strobe;
   logic ext_rise;
   logic ext_fall;
   logic shift_en;
   logic cnt_en;
   logic ext_sel;
   logic do_now;

   // Pin synchronisers
   ssc_sync u_sync_sck_a (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce),
      .i_async(i_sck_a), .o_sync(sck_a_s));
   ssc_sync u_sync_sck_b (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce),
      .i_async(i_sck_b), .o_sync(sck_b_s));
   ssc_sync u_sync_di_a (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce),
      .i_async(i_di_a), .o_sync(di_a_s));
   ssc_sync u_sync_di_b (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce),
      .i_async(i_di_b), .o_sync(di_b_s));

   // Pin group routing of inputs
   assign sck_s = pin_group_q ? sck_b_s : sck_a_s; // R14
   assign di_s = pin_group_q ? di_b_s : di_a_s; // R14

   // Strobe and edge decode
   assign ctrl_wr = i_wr && (i_addr == ssc_pkg::ADDR_CTRL);
   assign soft_strobe = ctrl_wr && i_wdata[ssc_pkg::CLK_STROBE_POS];
   assign toggle_strobe = ctrl_wr && i_wdata[ssc_pkg::TOGGLE_POS];
   assign ext_rise = sck_s && !sck_prev_q;
   assign ext_fall = !sck_s && sck_prev_q;
   assign ext_sel = cs_q[1]; // R10

   // Clock source selection for shift register and counter
   always_comb
   begin
      shift_en = 1'b0;
      cnt_en = 1'b0;
      case (ssc_pkg::ssc_cs_type'(cs_q)) // R01
         ssc_pkg::SSC_CS_SOFT:
         begin
            shift_en = soft_strobe; // R04 R06
            cnt_en = soft_strobe; // R06
         end
         ssc_pkg::SSC_CS_TIMER:
         begin
            shift_en = i_timer_match; // R05
            cnt_en = i_timer_match;
         end
         ssc_pkg::SSC_CS_EXT_RISE:
         begin
            shift_en = ext_rise; // R05
            cnt_en = clk_sel_q ? toggle_strobe : (ext_rise || ext_fall); // R13
         end
         ssc_pkg::SSC_CS_EXT_FALL:
         begin
            shift_en = ext_fall; // R05
            cnt_en = clk_sel_q ? toggle_strobe : (ext_rise || ext_fall); // R13
         end
         default:
         begin
            shift_en = 1'b0;
            cnt_en = 1'b0;
         end
      endcase
   end

   // Control register
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         cs_q <= ssc_pkg::CS_RESET;
         clk_sel_q <= ssc_pkg::CLK_SEL_RESET;
      end
      else if (i_ce && ctrl_wr)
      begin
         cs_q <= i_wdata[ssc_pkg::CS_HI:ssc_pkg::CS_LO];
         clk_sel_q <= i_wdata[ssc_pkg::CLK_STROBE_POS]; // R10
      end
   end

   // Pin position register
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         pin_group_q <= ssc_pkg::PIN_GROUP_RESET;
      end
      else if (i_ce && i_wr && (i_addr == ssc_pkg::ADDR_PINPOS))
      begin
         pin_group_q <= i_wdata[ssc_pkg::PIN_GROUP_POS]; // R14
      end
   end

   // Input history: previous-cycle data bit and clock level
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         di_prev_q <= 1'h0;
         sck_prev_q <= 1'h0;
      end
      else if (i_ce)
      begin
         di_prev_q <= di_s;
         sck_prev_q <= sck_s;
      end
   end

   // Shift data register; software write loads it
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         data_q <= ssc_pkg::DATA_RESET;
      end
      else if (i_ce)
      begin
         if (i_wr && (i_addr == ssc_pkg::ADDR_DATA))
         begin
            data_q <= i_wdata;
         end
         else if (shift_en)
         begin
            data_q <= {data_q[6:0], di_prev_q}; // R08
         end
      end
   end

   // Four-bit counter
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         cnt_q <= ssc_pkg::CNT_RESET;
      end
      else if (i_ce && cnt_en)
      begin
         cnt_q <= cnt_q + 4'h1; // R17
      end
   end

   // Serial clock port value
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         clk_port_q <= ssc_pkg::CLK_PORT_RESET;
      end
      else if (i_ce && toggle_strobe)
      begin
         clk_port_q <= ~clk_port_q; // R11
      end
   end

   // Output latch: updated on opposite edge for external clocking
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         do_latch_q <= 1'h0;
      end
      else if (i_ce)
      begin
         if (!ext_sel)
         begin
            do_latch_q <= data_q[7]; // R03
         end
         else if ((cs_q[0] && ext_rise) || (!cs_q[0] && ext_fall))
         begin
            do_latch_q <= data_q[7]; // R02
         end
      end
   end

   // Transparent path when not externally clocked
   assign do_now = ext_sel ? do_latch_q : data_q[7]; // R03 R07

   // Pin group routing of outputs
   assign o_do_a = pin_group_q ? 1'b0 : do_now;
   assign o_do_b = pin_group_q ? do_now : 1'b0;
   assign o_sck_a = clk_port_q;
   assign o_sck_b = clk_port_q;
   assign o_sck_oe_a = !pin_group_q && i_clk_pin_dir; // R14
   assign o_sck_oe_b = pin_group_q && i_clk_pin_dir; // R14

   // Completed byte into the buffer on counter wrap
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         pend_q <= 1'h0;
      end
      else if (i_ce)
      begin
         if (cnt_en && (cnt_q == 4'hF))
         begin
            pend_q <= 1'h1;
         end
         else if (buf_if.ready)
         begin
            pend_q <= 1'h0;
         end
      end
   end
   assign buf_if.valid = pend_q;
   assign buf_if.data = data_q;

   ssc_fifo2 u_fifo (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .in_if(buf_if),
      .o_valid(o_byte_valid), .o_data(o_byte_data), .i_ready(i_byte_ready));

   // Read data, one cycle after the read strobe
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         rdata_q <= 8'h00;
      end
      else if (i_ce)
      begin
         rdata_q <= 8'h00;
         if (i_rd)
         begin
            case (i_addr)
               ssc_pkg::ADDR_CTRL: rdata_q <= {4'h0, cs_q, 2'h0}; // R09
               ssc_pkg::ADDR_PINPOS: rdata_q <= {7'h00, pin_group_q}; // R15
               ssc_pkg::ADDR_DATA: rdata_q <= data_q;
               ssc_pkg::ADDR_STATUS: rdata_q <= {3'h0, clk_port_q, cnt_q};
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end
   assign o_rdata = rdata_q;

   // Checks
   a_strobe_shift: assert property (@(posedge i_mclk) disable iff (i_srst) // R06
      (i_ce && soft_strobe && cs_q == 2'h0 && !(i_addr == ssc_pkg::ADDR_DATA))
      |=> data_q == {$past(data_q[6:0]), $past(di_prev_q)})
      else $error("soft strobe did not shift");
   a_strobe_count: assert property (@(posedge i_mclk) disable iff (i_srst) // R17
      (i_ce && cnt_en) |=> cnt_q == $past(cnt_q) + 4'h1)
      else $error("counter did not step");
   a_no_clock_idle: assert property (@(posedge i_mclk) disable iff (i_srst) // R04
      (i_ce && cs_q == 2'h0 && !soft_strobe) |=> cnt_q == $past(cnt_q))
      else $error("counter moved without clock");
   a_toggle_port: assert property (@(posedge i_mclk) disable iff (i_srst) // R11
      (i_ce && toggle_strobe) |=> clk_port_q != $past(clk_port_q))
      else $error("toggle did not invert port");
   a_strobe_reads_zero: assert property (@(posedge i_mclk) disable iff (i_srst) // R09
      ($past(i_rd) && $past(i_addr) == ssc_pkg::ADDR_CTRL) |-> o_rdata[1:0] == 2'h0)
      else $error("strobe bits read nonzero");
   a_pinpos_reserved: assert property (@(posedge i_mclk) disable iff (i_srst) // R15
      ($past(i_rd) && $past(i_addr) == ssc_pkg::ADDR_PINPOS) |-> o_rdata[7:1] == 7'h00)
      else $error("reserved pin bits nonzero");
   a_transparent_out: assert property (@(posedge i_mclk) disable iff (i_srst) // R03
      !cs_q[1] |-> do_now == data_q[7])
      else $error("output latch not transparent");
   // Rising-edge sampling moves the output latch only on a fall, and the reverse
   a_ext_hold: assert property (@(posedge i_mclk) disable iff (i_srst) // R02
      (i_ce && cs_q == 2'h2 && !ext_fall) ##1 (cs_q == 2'h2) |-> $stable(do_latch_q))
      else $error("output moved off its edge");
   a_ext_hold_fall: assert property (@(posedge i_mclk) disable iff (i_srst) // R02
      (i_ce && cs_q == 2'h3 && !ext_rise) ##1 (cs_q == 2'h3) |-> $stable(do_latch_q))
      else $error("output moved off its rising edge");
   a_timer_shift: assert property (@(posedge i_mclk) disable iff (i_srst) // R05
      (cs_q == 2'h1 && i_timer_match) |-> shift_en && cnt_en)
      else $error("timer match ignored");
   a_toggle_count: assert property (@(posedge i_mclk) disable iff (i_srst) // R13
      (cs_q[1] && clk_sel_q) |-> cnt_en == toggle_strobe)
      else $error("toggle count mismatch");
   a_group_route: assert property (@(posedge i_mclk) disable iff (i_srst) // R14
      pin_group_q |-> (o_do_a == 1'b0 && o_do_b == do_now))
      else $error("pin group routing wrong");
endmodule : ssc_core
`default_nettype wire

// >>> ssc_partner.sv
// Partner model: an external serial master that clocks the link and swaps one byte.
// Assumes the bench calls xfer between frames and the block synchronises the pins itself.
`timescale 1ns/1ps
`default_nettype none
module ssc_partner
(
   input wire logic i_do,
   output logic o_sck,
   output logic o_di
);
   logic [7:0] rx_q;
   // Clock stands low between frames; data line starts high
   initial
   begin
      o_sck = 1'b0;
      o_di = 1'b1;
      rx_q = 8'h00;
   end
   // One byte MSB first at 200 ns a bit; data moves mid-low so either edge may sample it
   task automatic xfer(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--)
      begin
         o_di = tx[i];
         #50;
         o_sck = 1'b1;
         rx_q = {rx_q[6:0], i_do};
         #100;
         o_sck = 1'b0;
         #50;
      end
      o_di = ~o_di; // Released line shows the inverse, never a stale bit
   endtask : xfer
endmodule : ssc_partner
`default_nettype wire

// >>> tb_serial_shift_clock_select.sv
// Testbench: register tasks, external frames through the partner, buffer stall and drain.
// Assumes ssc_core with its package, interface and sub-modules compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_shift_clock_select;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic tmatch = 1'b0;
   logic dir = 1'b1;
   logic bready = 1'b0;
   logic [7:0] rdata;
   logic [7:0] bdata;
   logic sck, di, do_a, do_b, sck_a, sck_b, oe_a, oe_b, bvalid;
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;

   ssc_partner peer (.i_do(do_a), .o_sck(sck), .o_di(di));

   ssc_core uut (.i_mclk(clk), .i_srst(srst), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timer_match(tmatch), .i_clk_pin_dir(dir),
      .i_sck_a(sck), .i_sck_b(sck), .i_di_a(di), .i_di_b(di), .o_sck_a(sck_a),
      .o_sck_oe_a(oe_a), .o_sck_b(sck_b), .o_sck_oe_b(oe_b), .o_do_a(do_a), .o_do_b(do_b),
      .o_byte_valid(bvalid), .o_byte_data(bdata), .i_byte_ready(bready));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // Cycle ceiling cuts a hang short
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wreg

   // Read data stands only in the cycle after the strobe
   task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp, "read");
   endtask : rreg

   task automatic reset_dut;
      @(posedge clk);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
   endtask : reset_dut

   task automatic pulse_timer;
      @(posedge clk);
      tmatch <= 1'b1;
      @(posedge clk);
      tmatch <= 1'b0;
      #1;
   endtask : pulse_timer

   // Take one byte from the buffer with a single ready cycle
   task automatic pop(input logic [7:0] exp);
      chk({7'h0, bvalid}, 8'h01, "valid");
      chk(bdata, exp, "byte");
      @(posedge clk);
      bready <= 1'b1;
      @(posedge clk);
      bready <= 1'b0;
      #1;
   endtask : pop

   task automatic endt(input string n);
      $display("test %s done", n);
   endtask : endt

   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial
   begin
      reset_dut();
      for (int a = 0; a < 5; a++) rreg(4'(a), 8'h00);
      endt("reset");
      wreg(ssc_pkg::ADDR_DATA, 8'hA5);
      wreg(ssc_pkg::ADDR_CTRL, 8'h08);
      rreg(ssc_pkg::ADDR_CTRL, 8'h08);
      peer.xfer(8'h3C);
      for (int i = 0; i < 20 && bvalid !== 1'b1; i++) @(posedge clk);
      chk(peer.rx_q, 8'hA5, "peer rx");
      rreg(ssc_pkg::ADDR_STATUS, 8'h00);
      wreg(ssc_pkg::ADDR_CTRL, 8'h0C);
      peer.xfer(8'hC3);
      repeat (8) @(posedge clk);
      rreg(ssc_pkg::ADDR_DATA, 8'hC3);
      pop(8'h3C);
      pop(8'hC3);
      chk({7'h0, bvalid}, 8'h00, "drained");
      endt("external");
      wreg(ssc_pkg::ADDR_CTRL, 8'h0A);
      rreg(ssc_pkg::ADDR_CTRL, 8'h08);
      for (int i = 0; i < 3; i++) wreg(ssc_pkg::ADDR_CTRL, 8'h0B);
      chk({7'h0, sck_a}, 8'h01, "port");
      rreg(ssc_pkg::ADDR_STATUS, 8'h13);
      wreg(ssc_pkg::ADDR_CTRL, 8'h08);
      wreg(ssc_pkg::ADDR_CTRL, 8'h09);
      rreg(ssc_pkg::ADDR_STATUS, 8'h03);
      endt("toggle");
      wreg(ssc_pkg::ADDR_DATA, 8'h81);
      wreg(ssc_pkg::ADDR_CTRL, 8'h00);
      rreg(ssc_pkg::ADDR_STATUS, 8'h03);
      wreg(ssc_pkg::ADDR_CTRL, 8'h02);
      chk({7'h0, do_a}, 8'h00, "data out");
      rreg(ssc_pkg::ADDR_DATA, 8'h02);
      rreg(ssc_pkg::ADDR_STATUS, 8'h04);
      endt("strobe");
      wreg(ssc_pkg::ADDR_DATA, 8'h40);
      wreg(ssc_pkg::ADDR_CTRL, 8'h04);
      wreg(ssc_pkg::ADDR_CTRL, 8'h06);
      rreg(ssc_pkg::ADDR_STATUS, 8'h04);
      pulse_timer();
      chk({7'h0, do_a}, 8'h01, "data out");
      pulse_timer();
      pulse_timer();
      rreg(ssc_pkg::ADDR_DATA, 8'h00);
      rreg(ssc_pkg::ADDR_STATUS, 8'h07);
      endt("timer");
      wreg(ssc_pkg::ADDR_PINPOS, 8'hFF);
      rreg(ssc_pkg::ADDR_PINPOS, 8'h01);
      chk({6'h0, oe_b, oe_a}, 8'h02, "clock enables");
      wreg(ssc_pkg::ADDR_DATA, 8'h80);
      chk({5'h0, sck_b, do_b, do_a}, 8'h02, "group pins");
      endt("pins");
      reset_dut();
      rreg(ssc_pkg::ADDR_PINPOS, 8'h00);
      endt("second reset");
      tally_and_finish();
   end
endmodule : tb_serial_shift_clock_select
`default_nettype wire
